/* File: design/pmp_mii_map.vh */
`ifndef PMP_MII_MAP_VH
`define PMP_MII_MAP_VH
// ****************************************
// timing and code constants
// ****************************************
// system clock period in ps (125 MHz)
`define PMP_CLK_PERIOD_PS 32'h0000_1F40
// heartbeat pulse length in ns
`define PMP_SQE_TIME_NS 32'h0000_03E8
// heartbeat pulse length in clock cycles, longest time rounds down
`define PMP_SQE_CYCLES ((`PMP_SQE_TIME_NS * 32'h0000_03E8) / `PMP_CLK_PERIOD_PS)
// link clock period and low phase in system cycles
// 25 MHz is five system cycles, so its two phases cannot be equal
`define PMP_PERIOD_100 8'h05
`define PMP_LOW_100 8'h03
// 2.5 MHz is fifty system cycles, split evenly
`define PMP_PERIOD_10 8'h32
`define PMP_LOW_10 8'h19
// halt marker on the encoder side
`define PMP_HALT_CODE 5'h04
`endif

/* File: design/pmp_mii_port.v */
// Notes on behaviour
// - The management clock is asynchronous, up to 25 MHz with no lower limit, so it is synchronised and edge-detected.
// - The management data line is open drain and is only driven low while the device sources data.
// - In half duplex, carrier sense follows receive or transmit activity.
// - In full duplex, carrier sense follows receive activity only.
// - In half duplex, collision is high while transmit and receive are both active.
// - In 10 Mb/s half duplex with heartbeat on, collision pulses for about 1 us right after each transmission.
// - In full duplex, collision is held low and no heartbeat is made.
// - The transmit clock is divided from the reference to 25 MHz or 2.5 MHz by speed.
// - Transmit nibbles are sampled on the rising edge of the device transmit clock.
// - At 100 Mb/s a transmit error during enable replaces the nibble with the halt code.
// - At 10 Mb/s the transmit error input is ignored.
// - The receive clock is supplied at 25 MHz or 2.5 MHz by speed.
// - Receive nibbles change on the falling edge of the receive clock.
// - Receive valid is high with valid nibbles and changes on the falling receive edge.
// - At 100 Mb/s a receive error is flagged for an invalid code inside a packet.
`include "pmp_mii_map.vh"
`default_nettype none
module pmp_mii_port #(
   parameter integer SQE_CYCLES = `PMP_SQE_CYCLES
) (
   input  wire       MCLK_IN,
   input  wire       RST_N_IN,
   input  wire       SPEED_100_IN,
   input  wire       FULL_DUPLEX_IN,
   input  wire       HEARTBEAT_EN_IN,
   input  wire [3:0] TXD_IN,
   input  wire       TX_EN_IN,
   input  wire       TX_ER_IN,
   input  wire       LINE_RX_VALID_IN,
   input  wire [3:0] LINE_RXD_IN,
   input  wire       LINE_RX_BADCODE_IN,
   input  wire       MDC_IN,
   input  wire       MDIO_IN,
   input  wire       MGMT_DRIVE_IN,
   input  wire       MGMT_BIT_IN,
   output reg        TX_CLK_OUT,
   output reg        RX_CLK_OUT,
   output reg  [3:0] RXD_OUT,
   output reg        RX_DV_OUT,
   output reg        RX_ER_OUT,
   output reg        CRS_OUT,
   output reg        COL_OUT,
   output reg  [4:0] LINE_TX_CODE_OUT,
   output reg        LINE_TX_VALID_OUT,
   output reg        MDC_RISE_OUT,
   output reg        MDIO_SAMPLE_OUT,
   output reg        MDIO_OUT,
   output reg        MDIO_OE_OUT
);
   // ****************************************
   // input synchronisers
   // ****************************************
   reg  [3:0] txd_s1;
   reg  [3:0] txd_s2;
   reg        txen_s1;
   reg        txen_s2;
   reg        txer_s1;
   reg        txer_s2;
   reg        mdc_s1;
   reg        mdc_s2;
   reg        mdc_d;
   reg        mdio_s1;
   reg        mdio_s2;
   reg  [7:0] div_cnt;
   reg        tx_active;
   reg  [9:0] sqe_cnt;
   wire [7:0] period_cnt;
   wire [7:0] low_cnt;
   wire       wrap;
   wire [7:0] next_div_cnt;
   wire       next_link_clk;
   wire       rise;
   wire       fall;

   // two-flop capture of pins from the MAC and management side
   always @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         txd_s1  <= 4'h0;
         txd_s2  <= 4'h0;
         txen_s1 <= 1'b0;
         txen_s2 <= 1'b0;
         txer_s1 <= 1'b0;
         txer_s2 <= 1'b0;
         mdc_s1  <= 1'b0;
         mdc_s2  <= 1'b0;
         mdc_d   <= 1'b0;
         mdio_s1 <= 1'b1;
         mdio_s2 <= 1'b1;
      end else begin
         txd_s1  <= TXD_IN;
         txd_s2  <= txd_s1;
         txen_s1 <= TX_EN_IN;
         txen_s2 <= txen_s1;
         txer_s1 <= TX_ER_IN;
         txer_s2 <= txer_s1;
         mdc_s1  <= MDC_IN;
         mdc_s2  <= mdc_s1;
         mdc_d   <= mdc_s2;
         mdio_s1 <= MDIO_IN;
         mdio_s2 <= mdio_s1;
      end
   end

   // ****************************************
   // link clock generation
   // ****************************************
   // divider limits picked by speed
   assign period_cnt    = SPEED_100_IN ? `PMP_PERIOD_100 : `PMP_PERIOD_10;
   assign low_cnt       = SPEED_100_IN ? `PMP_LOW_100 : `PMP_LOW_10;
   // low phase first, so the first high phase after reset is full length
   assign wrap          = (div_cnt >= period_cnt - 8'h01);
   assign next_div_cnt  = wrap ? 8'h00 : div_cnt + 8'h01;
   assign next_link_clk = (next_div_cnt >= low_cnt);
   // strobes mark the edge at which the registered clock moves
   assign rise          = next_link_clk && !TX_CLK_OUT;
   assign fall          = !next_link_clk && TX_CLK_OUT;

   always @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         div_cnt    <= 8'h00;
         TX_CLK_OUT <= 1'b0;
         RX_CLK_OUT <= 1'b0;
      end else begin
         div_cnt    <= next_div_cnt;
         TX_CLK_OUT <= next_link_clk;
         RX_CLK_OUT <= next_link_clk;
      end
   end

   // ****************************************
   // transmit path
   // ****************************************
   // sample on transmit clock rise
   always @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         LINE_TX_CODE_OUT  <= 5'h00;
         LINE_TX_VALID_OUT <= 1'b0;
         tx_active         <= 1'b0;
      end else if (rise) begin
         tx_active         <= txen_s2;
         LINE_TX_VALID_OUT <= txen_s2;
         if (txen_s2 && txer_s2 && SPEED_100_IN)
            LINE_TX_CODE_OUT <= `PMP_HALT_CODE;
         else
            LINE_TX_CODE_OUT <= {1'b1, txd_s2};
      end
   end

   // ****************************************
   // receive path
   // ****************************************
   // data on falling edge
   always @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         RXD_OUT   <= 4'h0;
         RX_DV_OUT <= 1'b0;
         RX_ER_OUT <= 1'b0;
      end else if (fall) begin
         RXD_OUT   <= LINE_RXD_IN;
         RX_DV_OUT <= LINE_RX_VALID_IN;
         RX_ER_OUT <= SPEED_100_IN && LINE_RX_VALID_IN && LINE_RX_BADCODE_IN;
      end
   end

   // ****************************************
   // carrier and collision
   // ****************************************
   // carrier sense, collision and the heartbeat timer
   always @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         CRS_OUT <= 1'b0;
         COL_OUT <= 1'b0;
         sqe_cnt <= 10'h000;
      end else begin
         if (FULL_DUPLEX_IN)
            CRS_OUT <= LINE_RX_VALID_IN;
         else
            CRS_OUT <= LINE_RX_VALID_IN || tx_active;
         if (rise && tx_active && !txen_s2 && !SPEED_100_IN && !FULL_DUPLEX_IN
             && HEARTBEAT_EN_IN)
            sqe_cnt <= SQE_CYCLES[9:0];
         else if (sqe_cnt != 10'h000)
            sqe_cnt <= sqe_cnt - 10'h001;
         if (FULL_DUPLEX_IN)
            COL_OUT <= 1'b0;
         else
            COL_OUT <= (tx_active && LINE_RX_VALID_IN) || (sqe_cnt != 10'h000);
      end
   end

   // ****************************************
   // management pins
   // ****************************************
   // edge found on synchronised clock
   always @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         MDC_RISE_OUT    <= 1'b0;
         MDIO_SAMPLE_OUT <= 1'b1;
         MDIO_OUT        <= 1'b0;
         MDIO_OE_OUT     <= 1'b0;
      end else begin
         MDC_RISE_OUT    <= mdc_s2 && !mdc_d;
         MDIO_SAMPLE_OUT <= mdio_s2;
         MDIO_OUT        <= 1'b0;
         MDIO_OE_OUT     <= MGMT_DRIVE_IN && !MGMT_BIT_IN;
      end
   end
endmodule // pmp_mii_port
`default_nettype wire

/* File: testbench/pmp_mac_model.sv */
`default_nettype none
module pmp_mac_model (
   input  wire logic       mclk,
   input  wire logic       tx_clk,
   output var  logic [3:0] txd,
   output var  logic       tx_en,
   output var  logic       tx_er
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle at time zero
   initial begin
      txd = 4'h0;
      tx_en = 1'h0;
      tx_er = 1'h0;
   end
   // one nibble per tx clock, enable only with data
   task automatic send(input logic [3:0] base, input int n, input logic er);
      for (int k = 0; k <= n; k++) begin
         @(posedge tx_clk);
         @(negedge mclk);
         tx_en = k < n;
         tx_er = er && k < n;
         txd = (k < n) ? base + k[3:0] : ~txd;
      end
   endtask
endmodule // pmp_mac_model
`default_nettype wire

/* File: testbench/pmp_mii_chk.sv */
`default_nettype none
module pmp_mii_chk (
   input wire logic       MCLK_IN,
   input wire logic       RST_N_IN,
   input wire logic       SPEED_100_IN,
   input wire logic       FULL_DUPLEX_IN,
   input wire logic       LINE_RX_VALID_IN,
   input wire logic       TX_CLK_OUT,
   input wire logic       RX_CLK_OUT,
   input wire logic [3:0] RXD_OUT,
   input wire logic       RX_DV_OUT,
   input wire logic       RX_ER_OUT,
   input wire logic       CRS_OUT,
   input wire logic       COL_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************
   // port checks
   // ****************
   default clocking dc @(posedge MCLK_IN); endclocking
   default disable iff (!RST_N_IN);
   // 25 MHz from 125 MHz: high for two cycles, low for three
   sequence tx_period; TX_CLK_OUT [*2] ##1 !TX_CLK_OUT [*3] ##1 TX_CLK_OUT; endsequence
   sequence rx_period; RX_CLK_OUT [*2] ##1 !RX_CLK_OUT [*3] ##1 RX_CLK_OUT; endsequence
   tx_fast_a: assert property ($rose(TX_CLK_OUT) && SPEED_100_IN |-> tx_period)
      else $error("tx clock wrong at 100");
   tx_slow_a: assert property (
      $rose(TX_CLK_OUT) && !SPEED_100_IN |-> ##25 $fell(TX_CLK_OUT))
      else $error("tx clock wrong at 10");
   rx_fast_a: assert property ($rose(RX_CLK_OUT) && SPEED_100_IN |-> rx_period)
      else $error("rx clock wrong at 100");
   rx_slow_a: assert property (
      $rose(RX_CLK_OUT) && !SPEED_100_IN |-> ##25 $fell(RX_CLK_OUT))
      else $error("rx clock wrong at 10");
   crs_rx_a: assert property (LINE_RX_VALID_IN |=> CRS_OUT)
      else $error("carrier missing");
   crs_full_a: assert property (FULL_DUPLEX_IN && !LINE_RX_VALID_IN |=> !CRS_OUT)
      else $error("carrier from transmit");
   col_full_a: assert property (FULL_DUPLEX_IN |=> !COL_OUT)
      else $error("collision in full duplex");
   col_idle_a: assert property (SPEED_100_IN && !LINE_RX_VALID_IN |=> !COL_OUT)
      else $error("collision without receive");
   // receive outputs move on falling clock
   rxd_edge_a: assert property (!$stable(RXD_OUT) |-> $fell(RX_CLK_OUT))
      else $error("rx data off edge");
   rxflag_edge_a: assert property (
      !$stable({RX_DV_OUT, RX_ER_OUT}) |-> $fell(RX_CLK_OUT))
      else $error("rx flags off edge");
endmodule // pmp_mii_chk
bind pmp_mii_port pmp_mii_chk pmp_mii_chk_i (.*);
`default_nettype wire

/* File: testbench/pmp_mii_port_tb_top.sv */
`default_nettype none
module pmp_mii_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************
   // bench
   // ****************
   localparam int SQE = 10;
   logic clk = 0, rst_n = 0, spd = 0, fdx = 0, hb = 0, rxv = 0, bad = 0, mdc = 0, mdrv = 0;
   logic mbit = 0;
   logic [3:0] lrxd = 4'h0, rxd, txd;
   logic [4:0] code;
   logic txc, rxc, dv, er, crs, col, lv, mrise, msamp, mdo, moe, ten, ter, txc_d = 0;
   logic [4:0] got[$];
   int mismatches = 0, n_compared = 0, i;
   wire mdio = moe ? mdo : 1'h1;
   pmp_mii_port #(.SQE_CYCLES(SQE)) pmp_mii_port_i (.MCLK_IN(clk), .RST_N_IN(rst_n),
      .SPEED_100_IN(spd), .FULL_DUPLEX_IN(fdx), .HEARTBEAT_EN_IN(hb),
      .TXD_IN(txd), .TX_EN_IN(ten), .TX_ER_IN(ter), .LINE_RX_VALID_IN(rxv), .LINE_RXD_IN(lrxd),
      .LINE_RX_BADCODE_IN(bad), .MDC_IN(mdc), .MDIO_IN(mdio), .MGMT_DRIVE_IN(mdrv),
      .MGMT_BIT_IN(mbit), .TX_CLK_OUT(txc), .RX_CLK_OUT(rxc), .RXD_OUT(rxd), .RX_DV_OUT(dv),
      .RX_ER_OUT(er), .CRS_OUT(crs), .COL_OUT(col), .LINE_TX_CODE_OUT(code),
      .LINE_TX_VALID_OUT(lv), .MDC_RISE_OUT(mrise), .MDIO_SAMPLE_OUT(msamp),
      .MDIO_OUT(mdo), .MDIO_OE_OUT(moe));
   pmp_mac_model pmp_mac_model_i (.mclk(clk), .tx_clk(txc), .txd(txd), .tx_en(ten), .tx_er(ter));
   // clock and watchdog
   initial forever #4 clk = ~clk;
   initial begin
      #100us;
      mismatches++;
      report_and_stop();
   end
   // collect each new line code
   always @(negedge clk) begin
      if (txc && !txc_d && lv) got.push_back(code);
      txc_d <= txc;
   end
   task chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // apply mode under reset
   task rst(input logic s, input logic f);
      @(negedge clk);
      {rst_n, spd, fdx, hb} = {1'h0, s, f, 1'h1};
      repeat (8) @(negedge clk);
      rst_n = 1'h1;
   endtask
   task t_tx(input logic s, input logic e);
      rst(s, 1'h0);
      got.delete();
      pmp_mac_model_i.send(4'h6, 3, e);
      repeat (s ? 12 : 120) @(negedge clk);
      chk(8'(got.size()), 8'h03);
      foreach (got[k]) chk(got[k], (e && s) ? 8'h04 : 8'h16 + k[7:0]);
   endtask
   task t_crs(input logic f);
      rst(1'h1, f);
      rxv = 1'h1;
      fork pmp_mac_model_i.send(4'h1, 8, 1'h0); join_none
      repeat (20) @(negedge clk);
      chk(crs, 8'h01);
      chk(col, {7'h0, !f});
      rxv = 1'h0;
      repeat (4) @(negedge clk);
      chk(crs, {7'h0, !f});
      wait fork;
   endtask
   // heartbeat only in half duplex with it switched on
   task t_hb(input logic h, input logic f);
      rst(1'h0, f);
      hb = h;
      pmp_mac_model_i.send(4'h3, 2, 1'h1);
      for (i = 0; i < 200 && col !== 1'h1; i++) @(negedge clk);
      for (i = 0; i < 50 && col === 1'h1; i++) @(negedge clk);
      chk(8'(i), (h && !f) ? 8'(SQE) : 8'h00);
   endtask
   task t_rx();
      rst(1'h1, 1'h0);
      {lrxd, bad, rxv} = {4'hA, 1'h1, 1'h1};
      for (i = 0; i < 16 && dv !== 1'h1; i++) @(negedge clk);
      chk(rxd, 8'h0A);
      chk(er, 8'h01);
      {bad, rxv, mdrv} = 3'h1;
      repeat (6) @(negedge clk);
      chk({moe, mdo, msamp}, 8'h04);
      mbit = 1'h1;
      repeat (6) @(negedge clk);
      chk({moe, mdo, msamp}, 8'h01);
      {mdrv, mdc} = 2'h1;
      for (i = 0; i < 8 && mrise !== 1'h1; i++) @(negedge clk);
      chk(mrise, 8'h01);
      @(negedge clk);
      chk(mrise, 8'h00);
   endtask
   task report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // main sequence
   initial begin
      t_tx(1'h1, 1'h0);
      t_tx(1'h1, 1'h1);
      t_tx(1'h0, 1'h1);
      t_crs(1'h0);
      t_crs(1'h1);
      t_hb(1'h1, 1'h0);
      t_hb(1'h0, 1'h0);
      t_hb(1'h1, 1'h1);
      t_rx();
      report_and_stop();
   end
endmodule // pmp_mii_port_tb_top
`default_nettype wire
